// ---- design/pcsel_pkg.sv ----
package pcsel_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int ADDR_W      = 20;
    localparam int NUM_SEL     = 7;
    localparam int WAIT_W      = 4;
    localparam int REGION_LSB  = 8;
    localparam int REGION_W    = 3;
    localparam int BASE_LSB    = REGION_LSB + REGION_W;
    localparam int BASE_W      = ADDR_W - BASE_LSB;
    localparam int NO_PIN_SEL  = 4;

    // ------------------------------------------------------------
    // pin indices with shared functions
    // ------------------------------------------------------------
    localparam int PIN_CTS_ENRX = 2;
    localparam int PIN_RTS_RTR  = 3;
    localparam int PIN_ADDR1    = 5;
    localparam int PIN_ADDR2    = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [NUM_SEL-1:0] PIN_RST_VAL = 7'h7F;
    localparam logic [NUM_SEL-1:0] PIN_RST_OE  = 7'h00;
    localparam logic [1:0]         ADDR_RST    = 2'h0;
    localparam logic [WAIT_W-1:0]  WAIT_RST    = 4'h0;

    typedef struct packed {
        logic              addr_strobe;
        logic              cycle_end;
        logic              io_space;
        logic [ADDR_W-1:0] addr;
    } pcsel_bus_t;

    typedef struct packed {
        logic [BASE_W-1:0] base;
        logic              block_io;
        logic              flow_control_enable_bit;
        logic              rx_enable_select;
        logic              rts_select;
        logic              address_extension_bit;
    } pcsel_cfg_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } pcsel_tx_state_t;

endpackage

// ---- design/pcsel_region_dec.sv ----
`timescale 1ns/1ps

module pcsel_region_dec #(
    parameter int REGION = 0
) (
    input  wire logic [pcsel_pkg::ADDR_W-1:0] addr_in,
    input  wire logic                         io_space_in,
    input  wire logic [pcsel_pkg::BASE_W-1:0] base_in,
    input  wire logic                         block_io_in,
    output logic                              hit_out
);

    localparam logic [pcsel_pkg::REGION_W-1:0] REGION_CODE = REGION[pcsel_pkg::REGION_W-1:0];

    wire logic space_match;
    wire logic base_match;
    wire logic region_match;

    // ------------------------------------------------------------
    // one 256-byte window above the block base
    // ------------------------------------------------------------
    assign space_match  = (io_space_in == block_io_in);
    assign base_match   = (addr_in[pcsel_pkg::ADDR_W-1:pcsel_pkg::BASE_LSB] == base_in);
    assign region_match = (addr_in[pcsel_pkg::BASE_LSB-1:pcsel_pkg::REGION_LSB] == REGION_CODE);
    assign hit_out      = space_match && base_match && region_match;

endmodule

// ---- design/pcsel_top.sv ----
// Functional notes
// - peripheral select wins over DRAM when both decode the address
// - during bus hold the select outputs float, pulled high outside
// - selects assert with the multiplexed address phase
// - each select covers 256 bytes, memory or I/O, from the base
// - selects five and six decode the sixth and seventh regions
// - pins two and three are selects while port 1 flow control is off
// - pin two is clear-to-send or receiver-enable input per select bit
// - transmit starts when clear-to-send asserted and data waits
// - clear-to-send checked only at frame start, never mid-frame
// - receiver enabled by the receiver-enable request input
// - pin three drives request-to-send or ready-to-receive per select bit
// - request-to-send asserted while transmit register holds unsent data
// - ready-to-receive asserted while receive register holds no unread data
// - with extension bit 0, pins five and six give latched A1, A2
// - latched address outputs keep their value during bus hold
// - selects have extended wait-state settings
`timescale 1ns/1ps

module pcsel_top (
    input  wire logic                                          clk_in,
    input  wire logic                                          rst_b_in,
    input  wire pcsel_pkg::pcsel_bus_t                         bus_in,
    input  wire logic                                          hold_in,
    input  wire pcsel_pkg::pcsel_cfg_t                         cfg_in,
    input  wire logic [pcsel_pkg::NUM_SEL-1:0][pcsel_pkg::WAIT_W-1:0] sel_wait_in,
    input  wire logic                                          dram_hit_in,
    input  wire logic [pcsel_pkg::WAIT_W-1:0]                  dram_wait_in,
    input  wire logic [pcsel_pkg::NUM_SEL-1:0]                 sel_pin_in,
    input  wire logic                                          tx_pending_in,
    input  wire logic                                          tx_frame_done_in,
    input  wire logic                                          rx_full_in,
    output logic [pcsel_pkg::NUM_SEL-1:0]                      sel_pin_out,
    output logic [pcsel_pkg::NUM_SEL-1:0]                      sel_pin_oe_out,
    output logic                                               dram_grant_out,
    output logic [pcsel_pkg::WAIT_W-1:0]                       cycle_wait_out,
    output logic                                               wait_short_out,
    output logic                                               tx_start_out,
    output logic                                               rx_enable_out
);

    localparam int N = pcsel_pkg::NUM_SEL;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    wire logic [N-1:0]   hit;
    wire logic           any_hit;
    wire logic [N-1:0]   periph_select_n;
    wire logic           flow_on;
    wire logic           port1_clear_to_send;
    wire logic           port1_receiver_enable_req;
    wire logic           port1_request_to_send;
    wire logic           port1_ready_to_receive;
    wire logic           cts_ok;
    wire logic           start_frame;
    wire logic [1:0]     addr_bits_d;

    logic [N-1:0]                    sel_act_q;
    logic [N-1:0]                    sel_act_d;
    logic                            dram_grant_q;
    logic                            dram_grant_d;
    logic [1:0]                      addr_bits_q;
    logic [N-1:0]                    pin_q;
    logic [N-1:0]                    pin_d;
    logic [N-1:0]                    oe_q;
    logic [N-1:0]                    oe_d;
    logic [pcsel_pkg::WAIT_W-1:0]    wait_q;
    logic [pcsel_pkg::WAIT_W-1:0]    wait_d;
    logic                            wait_short_q;
    logic                            tx_start_q;
    logic                            rx_enable_q;
    pcsel_pkg::pcsel_tx_state_t      tx_state_q;
    pcsel_pkg::pcsel_tx_state_t      tx_state_d;

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    // window decode
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_dec
            pcsel_region_dec #(
                .REGION (g)
            ) pcsel_region_dec_inst (
                .addr_in     (bus_in.addr),
                .io_space_in (bus_in.io_space),
                .base_in     (cfg_in.base),
                .block_io_in (cfg_in.block_io),
                .hit_out     (hit[g])
            );
        end
    endgenerate

    assign any_hit = |hit;

    // ------------------------------------------------------------
    // cycle tracking
    // ------------------------------------------------------------
    // address phase latch
    always_comb begin
        sel_act_d = sel_act_q;
        if (bus_in.addr_strobe) begin
            sel_act_d = hit;
        end else if (bus_in.cycle_end) begin
            sel_act_d = '0;
        end
    end

    always_comb begin
        dram_grant_d = dram_grant_q;
        if (bus_in.addr_strobe) begin
            dram_grant_d = dram_hit_in && !any_hit;
        end else if (bus_in.cycle_end) begin
            dram_grant_d = 1'b0;
        end
    end

    // latch only on a new address
    assign addr_bits_d = bus_in.addr_strobe ? bus_in.addr[2:1] : addr_bits_q;

    always_comb begin
        wait_d = wait_q;
        if (bus_in.addr_strobe) begin
            wait_d = pcsel_pkg::WAIT_RST;
            for (int i = 0; i < N; i++) begin
                if (hit[i]) begin
                    wait_d = sel_wait_in[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sel_act_q    <= '0;
            dram_grant_q <= 1'b0;
            addr_bits_q  <= pcsel_pkg::ADDR_RST;
            wait_q       <= pcsel_pkg::WAIT_RST;
            wait_short_q <= 1'b0;
        end else begin
            sel_act_q    <= sel_act_d;
            dram_grant_q <= dram_grant_d;
            addr_bits_q  <= addr_bits_d;
            wait_q       <= wait_d;
            if (bus_in.addr_strobe) begin
                wait_short_q <= any_hit && dram_hit_in && (wait_d < dram_wait_in);
            end
        end
    end

    // ------------------------------------------------------------
    // pin function selection
    // ------------------------------------------------------------
    assign periph_select_n = ~sel_act_d;
    assign flow_on         = cfg_in.flow_control_enable_bit;

    // pins two and three treated low-active in both flow roles
    assign port1_clear_to_send       = !sel_pin_in[pcsel_pkg::PIN_CTS_ENRX];
    assign port1_receiver_enable_req = !sel_pin_in[pcsel_pkg::PIN_CTS_ENRX];
    assign port1_request_to_send     = tx_pending_in;
    assign port1_ready_to_receive    = !rx_full_in;

    always_comb begin
        pin_d = pcsel_pkg::PIN_RST_VAL;
        oe_d  = pcsel_pkg::PIN_RST_OE;
        for (int i = 0; i < N; i++) begin
            pin_d[i] = hold_in ? 1'b1 : periph_select_n[i];
            oe_d[i]  = !hold_in;
        end
        pin_d[pcsel_pkg::NO_PIN_SEL] = 1'b1;
        oe_d[pcsel_pkg::NO_PIN_SEL]  = 1'b0;
        if (flow_on) begin
            pin_d[pcsel_pkg::PIN_CTS_ENRX] = 1'b1;
            oe_d[pcsel_pkg::PIN_CTS_ENRX]  = 1'b0;
            pin_d[pcsel_pkg::PIN_RTS_RTR] = cfg_in.rts_select ? !port1_request_to_send
                                                              : !port1_ready_to_receive;
            oe_d[pcsel_pkg::PIN_RTS_RTR]  = 1'b1;
        end
        if (!cfg_in.address_extension_bit) begin
            pin_d[pcsel_pkg::PIN_ADDR1] = addr_bits_d[0];
            pin_d[pcsel_pkg::PIN_ADDR2] = addr_bits_d[1];
            oe_d[pcsel_pkg::PIN_ADDR1]  = 1'b1;
            oe_d[pcsel_pkg::PIN_ADDR2]  = 1'b1;
        end
    end

    // reset leaves all pins undriven so the outside pullups hold them high
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_q <= pcsel_pkg::PIN_RST_VAL;
            oe_q  <= pcsel_pkg::PIN_RST_OE;
        end else begin
            pin_q <= pin_d;
            oe_q  <= oe_d;
        end
    end

    // ------------------------------------------------------------
    // port 1 flow gating
    // ------------------------------------------------------------
    // clear-to-send only in that mode
    assign cts_ok      = !flow_on || cfg_in.rx_enable_select || port1_clear_to_send;
    assign start_frame = (tx_state_q == pcsel_pkg::TX_IDLE) && tx_pending_in && cts_ok;

    always_comb begin
        tx_state_d = tx_state_q;
        unique case (tx_state_q)
            pcsel_pkg::TX_IDLE: begin
                if (start_frame) begin
                    tx_state_d = pcsel_pkg::TX_SEND;
                end
            end
            pcsel_pkg::TX_SEND: begin
                if (tx_frame_done_in) begin
                    tx_state_d = pcsel_pkg::TX_IDLE;
                end
            end
            default: begin
                tx_state_d = pcsel_pkg::TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_state_q  <= pcsel_pkg::TX_IDLE;
            tx_start_q  <= 1'b0;
            rx_enable_q <= 1'b0;
        end else begin
            tx_state_q  <= tx_state_d;
            tx_start_q  <= start_frame;
            rx_enable_q <= !flow_on || !cfg_in.rx_enable_select || port1_receiver_enable_req;
        end
    end

    assign sel_pin_out    = pin_q;
    assign sel_pin_oe_out = oe_q;
    assign dram_grant_out = dram_grant_q;
    assign cycle_wait_out = wait_q;
    assign wait_short_out = wait_short_q;
    assign tx_start_out   = tx_start_q;
    assign rx_enable_out  = rx_enable_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_tx_begin;
        (tx_state_q == pcsel_pkg::TX_IDLE) && tx_pending_in && cts_ok;
    endsequence

    sequence s_tx_hold;
        tx_state_q == pcsel_pkg::TX_SEND && !tx_start_out;
    endsequence

    dram_precedence_a: assert property (
        bus_in.addr_strobe && any_hit |=> !dram_grant_out
    ) else $error("dram granted over peripheral select");

    hold_float_a: assert property (
        hold_in |=> !sel_pin_oe_out[0] && !sel_pin_oe_out[1] && sel_pin_out[0]
    ) else $error("select driven during hold");

    cs_assert_a: assert property (
        bus_in.addr_strobe && !hold_in && bus_in.addr[10:8] == 3'h1 && hit[1]
        |=> !sel_pin_out[1] && sel_pin_oe_out[1]
    ) else $error("select not asserted with address");

    region_six_a: assert property (
        bus_in.addr_strobe && !hold_in && cfg_in.address_extension_bit && hit[5]
        |=> !sel_pin_out[5] && sel_pin_out[6]
    ) else $error("wrong region on select five");

    cs_release_a: assert property (
        bus_in.cycle_end && !bus_in.addr_strobe ##1 !bus_in.addr_strobe[*2]
        |-> sel_pin_out[0] && sel_pin_out[1]
    ) else $error("select held after cycle end");

    pin2_input_a: assert property (
        flow_on |=> !sel_pin_oe_out[pcsel_pkg::PIN_CTS_ENRX]
    ) else $error("pin two driven in flow mode");

    rts_drive_a: assert property (
        flow_on && cfg_in.rts_select |=> sel_pin_out[pcsel_pkg::PIN_RTS_RTR] == !$past(tx_pending_in)
    ) else $error("request-to-send wrong");

    rtr_drive_a: assert property (
        flow_on && !cfg_in.rts_select |=> sel_pin_out[pcsel_pkg::PIN_RTS_RTR] == $past(rx_full_in)
    ) else $error("ready-to-receive wrong");

    tx_start_a: assert property (
        s_tx_begin |=> tx_start_out ##1 !tx_start_out
    ) else $error("frame start missed");

    tx_no_stop_a: assert property (
        tx_state_q == pcsel_pkg::TX_SEND && !tx_frame_done_in |=> s_tx_hold
    ) else $error("frame disturbed mid-transfer");

    // ext must already be clear one cycle earlier, else the pin role change itself looks like a jump
    addr_keep_a: assert property (
        !cfg_in.address_extension_bit
        ##1 hold_in && !bus_in.addr_strobe && !cfg_in.address_extension_bit
        ##1 !cfg_in.address_extension_bit
        |-> $stable(sel_pin_out[pcsel_pkg::PIN_ADDR1]) && sel_pin_oe_out[pcsel_pkg::PIN_ADDR1]
            && $stable(sel_pin_out[pcsel_pkg::PIN_ADDR2])
    ) else $error("latched address changed in hold");

    window_miss_a: assert property (
        bus_in.addr_strobe
        && ((bus_in.io_space != cfg_in.block_io)
            || (bus_in.addr[pcsel_pkg::ADDR_W-1:pcsel_pkg::BASE_LSB] != cfg_in.base))
        |=> sel_pin_out[0] && sel_pin_out[1]
    ) else $error("select asserted outside its window");

    pin3_select_a: assert property (
        bus_in.addr_strobe && !flow_on && !hold_in && hit[pcsel_pkg::PIN_RTS_RTR]
        |=> !sel_pin_out[pcsel_pkg::PIN_RTS_RTR] && sel_pin_oe_out[pcsel_pkg::PIN_RTS_RTR]
    ) else $error("pin three not a select with flow off");

    rx_enable_a: assert property (
        flow_on && cfg_in.rx_enable_select
        |=> rx_enable_out == !$past(sel_pin_in[pcsel_pkg::PIN_CTS_ENRX])
    ) else $error("receiver enable not following request");

    addr_pins_a: assert property (
        bus_in.addr_strobe && !cfg_in.address_extension_bit
        |=> sel_pin_out[pcsel_pkg::PIN_ADDR1] == $past(bus_in.addr[1])
            && sel_pin_out[pcsel_pkg::PIN_ADDR2] == $past(bus_in.addr[2])
    ) else $error("latched address pins wrong");

    wait_pick_a: assert property (
        bus_in.addr_strobe && hit[6]
        |=> cycle_wait_out == $past(sel_wait_in[6])
    ) else $error("select wait count not applied");

endmodule

// ---- dv/pcsel_far_side.sv ----
`timescale 1ns/1ps

module pcsel_far_side (
    input  wire logic [pcsel_pkg::NUM_SEL-1:0] pin_val_in,
    input  wire logic [pcsel_pkg::NUM_SEL-1:0] pin_oe_in,
    input  wire logic                          req_b_in,
    output logic      [pcsel_pkg::NUM_SEL-1:0] pin_level_out
);
    // --------------------------------------------------------
    // pin resolution
    // --------------------------------------------------------
    // released pins pulled high
    // partner drives pin two only when released
    always_comb begin
        for (int i = 0; i < pcsel_pkg::NUM_SEL; i++) begin
            pin_level_out[i] = pin_oe_in[i] ? pin_val_in[i] : 1'b1;
        end
        if (!pin_oe_in[pcsel_pkg::PIN_CTS_ENRX]) begin
            pin_level_out[pcsel_pkg::PIN_CTS_ENRX] = req_b_in;
        end
    end
endmodule

// ---- dv/peripheral_chip_select_pins_bench.sv ----
`timescale 1ns/1ps

module peripheral_chip_select_pins_bench;
    localparam logic [8:0] BASE = 9'h0A5;
    logic                  clk_in;
    logic                  rst_b_in;
    pcsel_pkg::pcsel_bus_t bus;
    pcsel_pkg::pcsel_cfg_t cfg;
    logic                  hold, dram_hit, tx_pend, tx_done, rx_full, cts_b;
    logic [6:0][3:0]       sel_wait;
    logic [3:0]            dram_wait, cyc_wait;
    logic [6:0]            pin_in, pin_out, pin_oe;
    logic                  grant, short_w, tx_start, rx_en;
    int                    fail_count = 0;
    int                    checks = 0;
    int                    c;

    pcsel_top pcsel_top_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .bus_in(bus), .hold_in(hold),
        .cfg_in(cfg), .sel_wait_in(sel_wait), .dram_hit_in(dram_hit), .dram_wait_in(dram_wait),
        .sel_pin_in(pin_in), .tx_pending_in(tx_pend), .tx_frame_done_in(tx_done), .rx_full_in(rx_full),
        .sel_pin_out(pin_out), .sel_pin_oe_out(pin_oe), .dram_grant_out(grant), .cycle_wait_out(cyc_wait),
        .wait_short_out(short_w), .tx_start_out(tx_start), .rx_enable_out(rx_en));

    pcsel_far_side pcsel_far_side_inst (.pin_val_in(pin_out), .pin_oe_in(pin_oe), .req_b_in(cts_b),
        .pin_level_out(pin_in));

    always #25 clk_in = ~clk_in;

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    task automatic cmp_pins(input logic [6:0] got, input logic [6:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_val(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic strobe(input logic io, input logic [19:0] a);
        @(posedge clk_in);
        bus.addr_strobe <= 1'b1;
        bus.io_space <= io;
        bus.addr <= a;
        @(posedge clk_in);
        bus.addr_strobe <= 1'b0;
        #1;
    endtask

    task automatic end_cycle;
        @(posedge clk_in);
        bus.cycle_end <= 1'b1;
        @(posedge clk_in);
        bus.cycle_end <= 1'b0;
        #1;
    endtask

    task automatic count_starts(input int n);
        c = 0;
        repeat (n) begin
            @(posedge clk_in);
            #1;
            if (tx_start === 1'b1) c++;
        end
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_decode;
        for (int r = 0; r < 7; r++) begin
            strobe(1'b0, {BASE, r[2:0], (r[0] ? 8'hFF : 8'h00)});
            // regions five and six on their pins
            cmp_pins(pin_out, (r == 4) ? 7'h7F : ~(7'h01 << r));
            cmp_pins(pin_oe, 7'h6F);
            if (r != 4) cmp_val(cyc_wait, sel_wait[r]);
            end_cycle();
            cmp_pins(pin_out, 7'h7F);
        end
        strobe(1'b0, {BASE, 3'h7, 8'h10});
        cmp_pins(pin_out, 7'h7F);
        strobe(1'b1, {BASE, 3'h0, 8'h10});
        cmp_pins(pin_out, 7'h7F);
        @(posedge clk_in);
        cfg.block_io <= 1'b1;
        strobe(1'b1, {BASE, 3'h1, 8'h10});
        cmp_pins(pin_out, 7'h7D);
        end_cycle();
        @(posedge clk_in);
        cfg.block_io <= 1'b0;
    endtask

    task automatic t_dram;
        @(posedge clk_in);
        dram_hit <= 1'b1;
        strobe(1'b0, {BASE, 3'h0, 8'h20});
        cmp_val({3'h0, grant}, 4'h0);
        cmp_val({3'h0, short_w}, 4'h0);
        end_cycle();
        strobe(1'b0, {BASE, 3'h7, 8'h20});
        cmp_val({3'h0, grant}, 4'h1);
        end_cycle();
        @(posedge clk_in);
        dram_wait <= 4'hF;
        strobe(1'b0, {BASE, 3'h0, 8'h20});
        cmp_val({3'h0, short_w}, 4'h1);
        end_cycle();
        @(posedge clk_in);
        dram_wait <= 4'h3;
        dram_hit <= 1'b0;
    endtask

    task automatic t_hold;
        @(posedge clk_in);
        cfg.address_extension_bit <= 1'b0;
        // latch zeros so a floating, pulled-high pin cannot pass for a kept address
        strobe(1'b0, {BASE, 3'h1, 8'h00});
        cmp_pins(pin_out, 7'h1D);
        @(posedge clk_in);
        hold <= 1'b1;
        settle(2);
        cmp_pins(pin_oe, 7'h60);
        cmp_pins(pin_out, 7'h1F);
        cmp_pins(pin_in, 7'h1F);
        end_cycle();
        @(posedge clk_in);
        hold <= 1'b0;
        settle(2);
        cmp_pins(pin_out, 7'h1F);
        strobe(1'b0, {BASE, 3'h0, 8'h02});
        cmp_pins(pin_out, 7'h3E);
        end_cycle();
        @(posedge clk_in);
        cfg.address_extension_bit <= 1'b1;
    endtask

    task automatic t_flow;
        @(posedge clk_in);
        cfg.flow_control_enable_bit <= 1'b1;
        cfg.rts_select <= 1'b1;
        tx_pend <= 1'b1;
        settle(2);
        cmp_pins(pin_oe, 7'h6B);
        cmp_pins(pin_out & 7'h08, 7'h00);
        @(posedge clk_in);
        tx_pend <= 1'b0;
        settle(2);
        cmp_pins(pin_out & 7'h08, 7'h08);
        @(posedge clk_in);
        cfg.rts_select <= 1'b0;
        settle(2);
        cmp_pins(pin_out & 7'h08, 7'h00);
        @(posedge clk_in);
        rx_full <= 1'b1;
        settle(2);
        cmp_pins(pin_out & 7'h08, 7'h08);
        strobe(1'b0, {BASE, 3'h3, 8'h00});
        cmp_pins(pin_out & 7'h08, 7'h08);
        end_cycle();
        @(posedge clk_in);
        rx_full <= 1'b0;
    endtask

    task automatic t_serial;
        @(posedge clk_in);
        tx_pend <= 1'b1;
        count_starts(6);
        cmp_val(4'(c), 4'h0);
        @(posedge clk_in);
        cts_b <= 1'b0;
        count_starts(6);
        cmp_val(4'(c), 4'h1);
        @(posedge clk_in);
        cts_b <= 1'b1;
        count_starts(4);
        @(posedge clk_in);
        tx_done <= 1'b1;
        @(posedge clk_in);
        tx_done <= 1'b0;
        count_starts(6);
        cmp_val(4'(c), 4'h0);
        @(posedge clk_in);
        tx_pend <= 1'b0;
        cfg.rx_enable_select <= 1'b1;
        settle(3);
        cmp_val({3'h0, rx_en}, 4'h0);
        @(posedge clk_in);
        cts_b <= 1'b0;
        settle(3);
        cmp_val({3'h0, rx_en}, 4'h1);
        @(posedge clk_in);
        cts_b <= 1'b1;
        cfg.flow_control_enable_bit <= 1'b0;
        settle(3);
        cmp_val({3'h0, rx_en}, 4'h1);
    endtask

    initial begin
        clk_in = 1'b0;
        rst_b_in = 1'b0;
        bus = '0;
        cfg = '0;
        cfg.base = BASE;
        cfg.address_extension_bit = 1'b1;
        {hold, dram_hit, tx_pend, tx_done, rx_full} = 5'h00;
        cts_b = 1'b1;
        dram_wait = 4'h3;
        // overlap waits kept at or above the dram count
        for (int i = 0; i < 7; i++) sel_wait[i] = 4'h4 + 4'(i);
        settle(4);
        cmp_pins(pin_out, 7'h7F);
        cmp_pins(pin_oe, 7'h00);
        @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_decode();
        t_dram();
        t_hold();
        t_flow();
        t_serial();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        fail_count++;
        tally_and_finish();
    end
endmodule
